// ===== hdl/csb_sideband.v
// config sideband export and legacy interrupt message generation
`timescale 1ns/1ps
`include "csb_consts.vh"
// Behaviour
// - export bus, device, function of last cfg write
// - export six command register bits
// - mirror device control bits fourteen to zero
// - mirror link control bits seven to zero
// - falling request emits assert, sets status
// - rising request emits deassert, clears status
// - interrupt disable set for two cycles in a row suppresses messages, not status
module csb_sideband (
  input wire ref_clk,
  input wire rst,
  input wire cfg_wr_stb,
  input wire [`CSB_BUS_W-1:0] cfg_wr_bus,
  input wire [`CSB_DEV_W-1:0] cfg_wr_dev,
  input wire [`CSB_FUNC_W-1:0] cfg_wr_func,
  input wire [`CSB_CMD_W-1:0] cmd_reg_in,
  input wire [`CSB_DEVCTL_W-1:0] dev_ctl_in,
  input wire [`CSB_LNKCTL_W-1:0] lnk_ctl_in,
  input wire int_req_n,
  output wire [`CSB_BUS_W-1:0] bus_num,
  output wire [`CSB_DEV_W-1:0] dev_num,
  output wire [`CSB_FUNC_W-1:0] func_num,
  output wire [`CSB_CMD_W-1:0] cmd_reg_out,
  output wire [`CSB_DEVCTL_W-1:0] dev_ctl_out,
  output wire [`CSB_LNKCTL_W-1:0] lnk_ctl_out,
  output wire int_status,
  output wire msg_assert_intx,
  output wire msg_deassert_intx
);
  // ************************************
  // local reset values
  // ************************************
  localparam [`CSB_CMD_W-1:0] CMD_RST = `CSB_CMD_RST;
  localparam [`CSB_DEVCTL_W-1:0] DEVCTL_RST = `CSB_DEVCTL_RST;
  localparam [`CSB_LNKCTL_W-1:0] LNKCTL_RST = `CSB_LNKCTL_RST;

  // ************************************
  // decode functions
  // ************************************
  // edge between samples
  function req_edge;
    input prev_n;
    input cur_n;
    input to_low;
    begin
      req_edge = (prev_n != cur_n) & (cur_n != to_low);
    end
  endfunction

  function msg_block;
    input dis_now;
    input dis_prev;
    begin
      msg_block = dis_now & dis_prev;
    end
  endfunction

  // ************************************
  // declarations
  // ************************************
  reg int_req_n_r;
  wire int_req_n_nxt;
  reg intdis_r;
  wire intdis_nxt;
  wire intdis_now;
  wire msg_block_w;
  wire fall_w;
  wire rise_w;
  reg int_status_r;
  reg int_status_nxt;
  reg msg_assert_r;
  reg msg_assert_nxt;
  reg msg_deassert_r;
  reg msg_deassert_nxt;
  reg [`CSB_BUS_W-1:0] bus_num_r;
  reg [`CSB_BUS_W-1:0] bus_num_nxt;
  reg [`CSB_DEV_W-1:0] dev_num_r;
  reg [`CSB_DEV_W-1:0] dev_num_nxt;
  reg [`CSB_FUNC_W-1:0] func_num_r;
  reg [`CSB_FUNC_W-1:0] func_num_nxt;
  reg [`CSB_CMD_W-1:0] cmd_reg_r;
  wire [`CSB_CMD_W-1:0] cmd_reg_nxt;
  reg [`CSB_DEVCTL_W-1:0] dev_ctl_r;
  wire [`CSB_DEVCTL_W-1:0] dev_ctl_nxt;
  reg [`CSB_LNKCTL_W-1:0] lnk_ctl_r;
  wire [`CSB_LNKCTL_W-1:0] lnk_ctl_nxt;
  genvar g;

  // ************************************
  // request sampling
  // ************************************
  // sample every rising edge
  assign int_req_n_nxt = int_req_n;

  always @(posedge ref_clk) begin
    if (rst) begin
      int_req_n_r <= `CSB_REQ_RST;
    end else begin
      int_req_n_r <= int_req_n_nxt;
    end
  end

  assign fall_w = req_edge(int_req_n_r, int_req_n, `CSB_EDGE_FALL);
  assign rise_w = req_edge(int_req_n_r, int_req_n, `CSB_EDGE_RISE);

  // ************************************
  // interrupt disable history
  // ************************************
  assign intdis_now = cmd_reg_r[`CSB_CMD_INTDIS];
  assign intdis_nxt = intdis_now;

  always @(posedge ref_clk) begin
    if (rst) begin
      intdis_r <= `CSB_DIS_RST;
    end else begin
      intdis_r <= intdis_nxt;
    end
  end

  assign msg_block_w = msg_block(intdis_now, intdis_r);

  // ************************************
  // interrupt status
  // ************************************
  // status follows edges
  always @* begin
    int_status_nxt = int_status_r;
    if (fall_w) begin
      int_status_nxt = `CSB_STAT_SET;
    end else if (rise_w) begin
      int_status_nxt = `CSB_STAT_CLR;
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      int_status_r <= `CSB_STAT_RST;
    end else begin
      int_status_r <= int_status_nxt;
    end
  end

  // ************************************
  // interrupt messages
  // ************************************
  always @* begin
    msg_assert_nxt = `CSB_MSG_IDLE;
    msg_deassert_nxt = `CSB_MSG_IDLE;
    if (!msg_block_w) begin
      msg_assert_nxt = fall_w;
      msg_deassert_nxt = rise_w;
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      msg_assert_r <= `CSB_MSG_IDLE;
      msg_deassert_r <= `CSB_MSG_IDLE;
    end else begin
      msg_assert_r <= msg_assert_nxt;
      msg_deassert_r <= msg_deassert_nxt;
    end
  end

  // ************************************
  // configuration write capture
  // ************************************
  // capture on cfg write
  always @* begin
    bus_num_nxt = bus_num_r;
    dev_num_nxt = dev_num_r;
    func_num_nxt = func_num_r;
    if (cfg_wr_stb) begin
      bus_num_nxt = cfg_wr_bus;
      dev_num_nxt = cfg_wr_dev;
      func_num_nxt = cfg_wr_func;
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      bus_num_r <= `CSB_BUS_RST;
      dev_num_r <= `CSB_DEV_RST;
      func_num_r <= `CSB_FUNC_RST;
    end else begin
      bus_num_r <= bus_num_nxt;
      dev_num_r <= dev_num_nxt;
      func_num_r <= func_num_nxt;
    end
  end

  // ************************************
  // command bits
  // ************************************
  // command bits out
  generate
    for (g = 0; g < `CSB_CMD_W; g = g + 1) begin : g_cmd
      assign cmd_reg_nxt[g] = cmd_reg_in[g];
    end
  endgenerate

  always @(posedge ref_clk) begin
    if (rst) begin
      cmd_reg_r <= CMD_RST;
    end else begin
      cmd_reg_r <= cmd_reg_nxt;
    end
  end

  // ************************************
  // control register mirrors
  // ************************************
  // device control mirror
  assign dev_ctl_nxt = dev_ctl_in;

  always @(posedge ref_clk) begin
    if (rst) begin
      dev_ctl_r <= DEVCTL_RST;
    end else begin
      dev_ctl_r <= dev_ctl_nxt;
    end
  end

  assign lnk_ctl_nxt = lnk_ctl_in;

  always @(posedge ref_clk) begin
    if (rst) begin
      lnk_ctl_r <= LNKCTL_RST;
    end else begin
      lnk_ctl_r <= lnk_ctl_nxt;
    end
  end

  // ************************************
  // outputs
  // ************************************
  assign bus_num = bus_num_r;
  assign dev_num = dev_num_r;
  assign func_num = func_num_r;
  assign cmd_reg_out = cmd_reg_r;
  assign dev_ctl_out = dev_ctl_r;
  assign lnk_ctl_out = lnk_ctl_r;
  assign int_status = int_status_r;
  assign msg_assert_intx = msg_assert_r;
  assign msg_deassert_intx = msg_deassert_r;
endmodule

// ===== hdl/csb_consts.vh
// constants for the config sideband and legacy interrupt block
`ifndef CSB_CONSTS_VH
`define CSB_CONSTS_VH
`define CSB_BUS_W 8
`define CSB_DEV_W 5
`define CSB_FUNC_W 3
`define CSB_CMD_W 6
`define CSB_DEVCTL_W 15
`define CSB_LNKCTL_W 8
`define CSB_CMD_INTDIS 5
`define CSB_CMD_SERR 4
`define CSB_CMD_PERR 3
`define CSB_CMD_BME 2
`define CSB_CMD_MEM 1
`define CSB_CMD_IO 0
`define CSB_BUS_RST 8'h00
`define CSB_DEV_RST 5'h00
`define CSB_FUNC_RST 3'h0
`define CSB_CMD_RST 6'h00
`define CSB_DEVCTL_RST 15'h0000
`define CSB_LNKCTL_RST 8'h00
`define CSB_REQ_RST 1'h1
`define CSB_DIS_RST 1'h0
`define CSB_STAT_RST 1'h0
`define CSB_STAT_SET 1'h1
`define CSB_STAT_CLR 1'h0
`define CSB_MSG_IDLE 1'h0
`define CSB_EDGE_FALL 1'h1
`define CSB_EDGE_RISE 1'h0
`endif

// ===== dv/csb_chk.sv
// sideband checker
`timescale 1ns/1ps
module csb_chk (
  input wire ref_clk,
  input wire rst,
  input wire cfg_wr_stb,
  input wire [7:0] cfg_wr_bus,
  input wire [4:0] cfg_wr_dev,
  input wire [2:0] cfg_wr_func,
  input wire [5:0] cmd_reg_in,
  input wire [14:0] dev_ctl_in,
  input wire [7:0] lnk_ctl_in,
  input wire int_req_n,
  input wire [7:0] bus_num,
  input wire [4:0] dev_num,
  input wire [2:0] func_num,
  input wire [5:0] cmd_reg_out,
  input wire [14:0] dev_ctl_out,
  input wire [7:0] lnk_ctl_out,
  input wire int_status,
  input wire msg_assert_intx,
  input wire msg_deassert_intx
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_b;
    cfg_wr_stb |=> {bus_num, dev_num, func_num} ==
      $past({cfg_wr_bus, cfg_wr_dev, cfg_wr_func});
  endproperty
  a_b: assert property (p_b) else $error("bus numbers not captured");
  property p_c;
    1 |=> cmd_reg_out == $past(cmd_reg_in);
  endproperty
  a_c: assert property (p_c) else $error("command bits wrong");
  property p_d;
    1 |=> dev_ctl_out == $past(dev_ctl_in);
  endproperty
  a_d: assert property (p_d) else $error("device control wrong");
  property p_l;
    1 |=> lnk_ctl_out == $past(lnk_ctl_in);
  endproperty
  a_l: assert property (p_l) else $error("link control wrong");
  property p_a;
    $fell(int_req_n) && !(cmd_reg_out[5] && $past(cmd_reg_out[5])) |=>
      msg_assert_intx && int_status;
  endproperty
  a_a: assert property (p_a) else $error("assert message missing");
  property p_e;
    $rose(int_req_n) && !(cmd_reg_out[5] && $past(cmd_reg_out[5])) |=>
      msg_deassert_intx && !int_status;
  endproperty
  a_e: assert property (p_e) else $error("deassert message missing");
  property p_s;
    cmd_reg_out[5] && $past(cmd_reg_out[5]) |=> !msg_assert_intx && !msg_deassert_intx;
  endproperty
  a_s: assert property (p_s) else $error("message not suppressed");
  property p_t;
    $fell(int_req_n) |=> int_status;
  endproperty
  a_t: assert property (p_t) else $error("status not set while disabled");
  property p_r;
    $rose(cmd_reg_out[5]) && $rose(int_req_n) |=> msg_deassert_intx;
  endproperty
  a_r: assert property (p_r) else $error("release gave no deassert");
  property p_q;
    $stable(int_req_n) |=> !msg_assert_intx && !msg_deassert_intx;
  endproperty
  a_q: assert property (p_q) else $error("message without edge");
endmodule
bind csb_sideband csb_chk csb_chk_inst(.*);

// ===== dv/csb_user.sv
// user logic model
`timescale 1ns/1ps
module csb_user (
  input wire raw_n,
  input wire intdis,
  input wire use_or,
  output wire int_req_n
);
  assign int_req_n = raw_n | (intdis & use_or);
endmodule

// ===== dv/testbench.sv
// sideband testbench
`timescale 1ns/1ps
`define CK(nm, e, g) begin \
  n_tests++; \
  if ((g) !== (e)) begin \
    fails++; \
    $display("[ERR] %s exp %0h got %0h", nm, (e), (g)); \
  end \
end
module testbench;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic cfg_wr_stb = 1'b0;
  logic [7:0] cfg_wr_bus = 8'h00;
  logic [4:0] cfg_wr_dev = 5'h00;
  logic [2:0] cfg_wr_func = 3'h0;
  logic [5:0] cmd_reg_in = 6'h00;
  logic [14:0] dev_ctl_in = 15'h0000;
  logic [7:0] lnk_ctl_in = 8'h00;
  logic int_req_n;
  logic [7:0] bus_num;
  logic [4:0] dev_num;
  logic [2:0] func_num;
  logic [5:0] cmd_reg_out;
  logic [14:0] dev_ctl_out;
  logic [7:0] lnk_ctl_out;
  logic int_status;
  logic msg_assert_intx;
  logic msg_deassert_intx;
  logic r = 1'b1;
  logic use_or = 1'b1;
  logic d1 = 1'b0;
  logic d2 = 1'b0;
  logic d3 = 1'b0;
  logic qp = 1'b1;
  logic q;
  logic [7:0] eb = 8'h00;
  logic [4:0] ed = 5'h00;
  logic [2:0] ef = 3'h0;
  int i;
  int fails = 0;
  int n_tests = 0;
  csb_sideband csb_sideband_inst (
    .ref_clk(ref_clk),
    .rst(rst),
    .cfg_wr_stb(cfg_wr_stb),
    .cfg_wr_bus(cfg_wr_bus),
    .cfg_wr_dev(cfg_wr_dev),
    .cfg_wr_func(cfg_wr_func),
    .cmd_reg_in(cmd_reg_in),
    .dev_ctl_in(dev_ctl_in),
    .lnk_ctl_in(lnk_ctl_in),
    .int_req_n(int_req_n),
    .bus_num(bus_num),
    .dev_num(dev_num),
    .func_num(func_num),
    .cmd_reg_out(cmd_reg_out),
    .dev_ctl_out(dev_ctl_out),
    .lnk_ctl_out(lnk_ctl_out),
    .int_status(int_status),
    .msg_assert_intx(msg_assert_intx),
    .msg_deassert_intx(msg_deassert_intx)
  );
  csb_user csb_user_inst (
    .raw_n(r),
    .intdis(cmd_reg_out[5]),
    .use_or(use_or),
    .int_req_n(int_req_n)
  );
  // message held back only if disabled two cycles
  function automatic logic exp_ast(logic q_prev, logic q_now, logic dn, logic dp);
    return q_prev & !q_now & !(dn & dp);
  endfunction
  function automatic logic exp_dst(logic q_prev, logic q_now, logic dn, logic dp);
    return !q_prev & q_now & !(dn & dp);
  endfunction
  task finish_test;
    $display("fails %0d n_tests %0d", fails, n_tests);
    if (fails == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial forever #2 ref_clk = ~ref_clk;
  initial begin
    void'($urandom(81347));
    repeat (6) @(negedge ref_clk);
    rst = 1'b0;
    for (i = 0; i < 400; i++) begin
      d3 = d2;
      d2 = d1;
      if (i == 200) use_or = 1'b0;
      if (i % 16 == 0) r = ~r;
      // without the OR, disable moves only while released
      if (i % 16 == 7 && (use_or || r)) d1 = 1'($urandom);
      if (i == 7 || i == 55) d1 = 1'b1;
      if (i == 23 || i == 71) d1 = 1'b0;
      cmd_reg_in = {d1, 5'($urandom)};
      cfg_wr_stb = 1'($urandom);
      dev_ctl_in = 15'($urandom);
      {cfg_wr_bus, cfg_wr_dev, cfg_wr_func, lnk_ctl_in} = 24'($urandom);
      if (cfg_wr_stb) {eb, ed, ef} = {cfg_wr_bus, cfg_wr_dev, cfg_wr_func};
      q = r | (d2 & use_or);
      @(negedge ref_clk);
      `CK("bus_num", eb, bus_num)
      `CK("dev_num", ed, dev_num)
      `CK("func_num", ef, func_num)
      `CK("cmd_reg_out", cmd_reg_in, cmd_reg_out)
      `CK("dev_ctl_out", dev_ctl_in, dev_ctl_out)
      `CK("lnk_ctl_out", lnk_ctl_in, lnk_ctl_out)
      `CK("int_status", !q, int_status)
      `CK("msg_assert_intx", exp_ast(qp, q, d2, d3), msg_assert_intx)
      `CK("msg_deassert_intx", exp_dst(qp, q, d2, d3), msg_deassert_intx)
      `CK("msg_suppressed", 1'b0, d2 & d3 & (msg_assert_intx | msg_deassert_intx))
      qp = q;
    end
    finish_test;
  end
endmodule
